// file: pkg/rse_consts.vh
`ifndef RSE_CONSTS_VH
`define RSE_CONSTS_VH
// ==========================================================================
// defaults
`define RSE_SYM_W_DEF 8
`define RSE_N_DEF 204
`define RSE_R_DEF 16
`define RSE_FIELD_DEF 285
`define RSE_GENSTART_DEF 0
`define RSE_CNT_W_DEF 8
`define RSE_SYM_W_MIN 4
`define RSE_SYM_W_MAX 8
// ==========================================================================
// timing
`define RSE_LATENCY 2
// ==========================================================================
// states
`define RSE_ST_INIT 2'h0
`define RSE_ST_DATA 2'h1
`define RSE_ST_CHK 2'h2
`endif

// file: sim/rse_encoder_properties.sv
// ====
// encoder port checker
module rse_enc_chk #(
    parameter SYM_W = 8,
    parameter R = 16
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [SYM_W-1:0] IN_DATA,
    input wire logic IN_VALID,
    input wire logic IN_LAST,
    input wire logic IN_READY,
    input wire logic [SYM_W-1:0] OUT_DATA,
    input wire logic OUT_VALID,
    input wire logic OUT_CHECK,
    input wire logic OUT_LAST,
    input wire logic CFG_ERR
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LST_D = R + 2;
    logic [7:0] chk_cnt_r;
    wire tk = IN_VALID && IN_READY;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) chk_cnt_r <= 8'h00;
        else chk_cnt_r <= OUT_CHECK ? chk_cnt_r + 8'h01 : 8'h00;
    end
    a_two_cyc_lat: assert property (
        tk |-> ##2 (OUT_VALID && !OUT_CHECK && OUT_DATA == $past(IN_DATA, 2)))
        else $error("info symbol late or altered");
    a_out_from_take: assert property (
        OUT_VALID && !OUT_CHECK |-> $past(tk, 2))
        else $error("info output without a take");
    a_check_valid: assert property (OUT_CHECK |-> OUT_VALID)
        else $error("check flag without valid");
    a_ready_drop: assert property (tk && IN_LAST |=> !IN_READY)
        else $error("ready stays after last symbol");
    a_last_delay: assert property (
        tk && IN_LAST |-> ##LST_D (OUT_LAST && OUT_CHECK))
        else $error("last check symbol at wrong cycle");
    a_check_count: assert property (
        OUT_LAST |-> OUT_CHECK && chk_cnt_r == R - 1)
        else $error("wrong number of check symbols");
    a_ready_back: assert property (OUT_LAST |-> IN_READY)
        else $error("ready not back with last check");
    a_last_once: assert property (OUT_LAST |=> !OUT_LAST)
        else $error("last flag longer than one cycle");
    a_cfg_valid: assert property (!CFG_ERR)
        else $error("valid setup flagged as error");
    c_last_take: cover property (tk && IN_LAST);
    c_refused: cover property (IN_VALID && !IN_READY);
    c_block_end: cover property (OUT_LAST);
endmodule
bind rse_encoder rse_enc_chk #(.SYM_W(SYM_W), .R(R)) i_rse_enc_chk (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .IN_DATA(IN_DATA),
    .IN_VALID(IN_VALID), .IN_LAST(IN_LAST), .IN_READY(IN_READY),
    .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID), .OUT_CHECK(OUT_CHECK),
    .OUT_LAST(OUT_LAST), .CFG_ERR(CFG_ERR));

// file: sim/rse_encoder_tb.sv
// ====
// encoder bench with reference model
module rse_encoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int R = 16;
    localparam int K = 188;
    logic SYS_CLK, RST_N, en, gaps;
    logic [31:0] rnd;
    logic [7:0] klen;
    wire [7:0] ind, outd;
    wire inv, inl, rdy, outv, outc, outl, cfe;
    int error_cnt, comparisons, done, n, a, fb, e, kcnt, xv;
    int q[$];
    int g[R+1];
    int rem[R];
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int gm(input int x, input int y);
        int p;
        p = 0;
        for (int i = 0; i < 8; i++) begin
            if (y[i]) p ^= x;
            x = x << 1;
            if (x[8]) x ^= 9'h11d;
        end
        return p;
    endfunction
    task cmp(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task print_verdict;
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task run(input logic gp, input int k, input int nb);
        @(negedge SYS_CLK);
        en <= 1'b1;
        gaps <= gp;
        klen <= k[7:0];
        e = done + nb;
        n = 0;
        while (done < e && n < 5000) begin
            @(negedge SYS_CLK);
            n++;
        end
        cmp({9'h000, done >= e}, 10'h001);
    endtask
    rse_encoder i_rse_encoder (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .IN_DATA(ind), .IN_VALID(inv),
        .IN_LAST(inl), .IN_READY(rdy), .OUT_DATA(outd), .OUT_VALID(outv),
        .OUT_CHECK(outc), .OUT_LAST(outl), .CFG_ERR(cfe));
    rse_src i_rse_src (
        .clk(SYS_CLK), .en(en), .gaps(gaps), .rnd(rnd), .klen(klen),
        .rdy(rdy), .vld(inv), .dat(ind), .lst(inl));
    // ====
    // model: feedback register per taken symbol
    always @(posedge SYS_CLK) begin
        if (RST_N && inv && rdy) begin
            fb = ind ^ rem[R-1];
            for (int j = R - 1; j > 0; j--) rem[j] = rem[j-1] ^ gm(fb, g[j]);
            rem[0] = gm(fb, g[0]);
            q.push_back(ind);
            kcnt++;
            if (inl || kcnt == K) begin
                for (int j = R - 1; j >= 0; j--)
                    q.push_back(10'h200 | ((j == 0) << 8) | rem[j]);
                rem = '{default: 0};
                kcnt = 0;
                done++;
            end
        end
    end
    always @(negedge SYS_CLK) begin
        rnd <= lfsr(rnd);
        if (outv === 1'b1) begin
            xv = q.size() ? q.pop_front() : -1;
            cmp({outc, outl, outd}, xv[9:0]);
        end
    end
    initial begin
        SYS_CLK = 1'b0;
        forever #20 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        #2000000;
        error_cnt++;
        print_verdict;
    end
    initial begin
        RST_N = 1'b0;
        en = 1'b0;
        gaps = 1'b0;
        klen = 8'hbc;
        rnd = 32'h3e5f6ffa;
        rem = '{default: 0};
        g = '{default: 0};
        g[0] = 1;
        a = 1;
        for (int i = 0; i < R; i++) begin
            for (int j = i + 1; j > 0; j--) g[j] = g[j-1] ^ gm(g[j], a);
            g[0] = gm(g[0], a);
            a = gm(a, 2);
        end
        repeat (12) @(posedge SYS_CLK);
        @(negedge SYS_CLK) RST_N = 1'b1;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            #1 n++;
        end while (rdy !== 1'b1 && n < 100);
        cmp(n[9:0], 10'h011);
        run(1'b0, K, 2);
        run(1'b1, K, 1);
        run(1'b1, 1, 3);
        run(1'b0, 5, 2);
        run(1'b1, 200, 2);
        en <= 1'b0;
        n = 0;
        while (q.size() > 0 && n < 1000) begin
            @(negedge SYS_CLK);
            n++;
        end
        cmp(q.size(), 10'h000);
        cmp({9'h000, cfe}, 10'h000);
        print_verdict;
    end
endmodule

// file: sim/rse_src.sv
// ====
// upstream symbol source, holds offer until taken
module rse_src (
    input wire logic clk,
    input wire logic en,
    input wire logic gaps,
    input wire logic [31:0] rnd,
    input wire logic [7:0] klen,
    input wire logic rdy,
    output logic vld,
    output logic [7:0] dat,
    output logic lst
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tk_r = 1'b0;
    int cnt = 0;
    initial begin
        vld = 1'b0;
        dat = 8'h00;
        lst = 1'b0;
    end
    always @(posedge clk) begin
        tk_r <= vld && rdy;
        if (vld && rdy) cnt <= lst ? 0 : cnt + 1;
    end
    always @(negedge clk) begin
        if (!vld || tk_r) begin
            vld <= en && (!gaps || rnd[0]);
            dat <= rnd[15:8];
            lst <= cnt >= klen - 1;
        end
    end
endmodule

// file: verilog/rse_encoder.v
// Contract
// RULE_01: symbol width four to eight bits
// RULE_02: information symbols first, then check symbols
// RULE_03: arithmetic in chosen valid field
// RULE_04: codeword length at most 2^m minus 1
// RULE_05: check count is twice corrected errors
// RULE_06: first generator root is a parameter
// RULE_07: two symbol clocks input to output
// RULE_08: one symbol per clock, single clock
// RULE_09: any block length, one build
// RULE_10: bursts and continuous streams both work
// RULE_11: defaults give 188 plus 16 check
// RULE_12: generator is product of root factors
// RULE_13: remainder in feedback register per symbol
`include "rse_consts.vh"
module rse_encoder #(
    parameter SYM_W = `RSE_SYM_W_DEF,
    parameter N = `RSE_N_DEF,
    parameter R = `RSE_R_DEF,
    parameter FIELD = `RSE_FIELD_DEF,
    parameter GENSTART = `RSE_GENSTART_DEF,
    parameter CNT_W = `RSE_CNT_W_DEF
) (
    input wire SYS_CLK,
    input wire RST_N,
    input wire [SYM_W-1:0] IN_DATA,
    input wire IN_VALID,
    input wire IN_LAST,
    output reg IN_READY,
    output reg [SYM_W-1:0] OUT_DATA,
    output reg OUT_VALID,
    output reg OUT_CHECK,
    output reg OUT_LAST,
    output reg CFG_ERR
);
    localparam W = SYM_W;
    localparam [W:0] FLD = FIELD[W:0];

    // ======================================================================
    // elaboration-time field helpers
    function integer alpha_pow;
        input integer e;
        integer k;
        integer v;
        begin
            v = 1;
            for (k = 0; k < e; k = k + 1) begin
                v = v << 1;
                if (v >= (1 << W)) begin
                    v = v ^ FIELD;
                end
            end
            alpha_pow = v;
        end
    endfunction

    function integer field_ok;
        input integer dummy;
        integer k;
        integer v;
        integer first;
        begin
            v = 1;
            first = 0;
            for (k = 1; k < (1 << W); k = k + 1) begin
                v = v << 1;
                if (v >= (1 << W)) begin
                    v = v ^ FIELD;
                end
                if (v == 1 && first == 0) begin
                    first = k;
                end
            end
            field_ok = (first == (1 << W) - 1) &&
                (FIELD >= (1 << W)) && (FIELD < (2 << W)) && (dummy == 0);
        end
    endfunction

    localparam CFG_OK = (W >= `RSE_SYM_W_MIN) && // RULE_01
        (W <= `RSE_SYM_W_MAX) &&
        (N <= (1 << W) - 1) && // RULE_04
        (R >= 2) && (R % 2 == 0) && (R < N) && // RULE_05
        (N < (1 << CNT_W)) &&
        (field_ok(0) != 0); // RULE_03
    localparam integer ROOT0_I = alpha_pow(GENSTART);
    localparam integer INFO_MAX_I = N - R - 1;
    localparam integer R_LAST_I = R - 1;
    localparam [W-1:0] ROOT0 = ROOT0_I[W-1:0]; // RULE_06
    localparam [CNT_W-1:0] INFO_MAX = INFO_MAX_I[CNT_W-1:0]; // RULE_11
    localparam [CNT_W-1:0] R_LAST = R_LAST_I[CNT_W-1:0];
    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam [W-1:0] SYM_ONE = {{(W-1){1'b0}}, 1'b1};

    // ======================================================================
    // state
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [CNT_W-1:0] cnt_r;
    reg [CNT_W-1:0] cnt_nxt;
    reg [CNT_W-1:0] info_r;
    reg [CNT_W-1:0] info_nxt;
    reg [W-1:0] root_r;
    reg [W-1:0] root_nxt;
    reg [R*W-1:0] gen_r;
    reg [R*W-1:0] gen_nxt;
    reg [R*W-1:0] lfsr_r;
    reg [R*W-1:0] lfsr_nxt;
    reg [W-1:0] d1_r;
    reg v1_r;
    reg l1_r;
    reg ready_nxt;
    reg [W-1:0] odata_nxt;
    reg ovalid_nxt;
    reg ocheck_nxt;
    reg olast_nxt;

    wire accept;
    wire last_eff;
    wire in_init;
    wire [W-1:0] fb;
    wire [R*W-1:0] prod;
    wire [R*W-1:0] gen_upd;
    wire [R*W-1:0] lfsr_upd;
    wire [R*W-1:0] lfsr_sh;

    assign accept = IN_VALID & IN_READY;
    // block ends on the marker or at the longest codeword
    assign last_eff = IN_LAST | (info_r == INFO_MAX); // RULE_09
    assign in_init = (state_r == `RSE_ST_INIT);
    assign fb = d1_r ^ lfsr_r[R*W-1 -: W]; // RULE_13

    // ======================================================================
    // shared multipliers: generator build, then remainder feedback
    genvar j;
    generate
        for (j = 0; j < R; j = j + 1) begin : g_tap
            wire [W-1:0] ma;
            wire [W-1:0] mb;
            assign ma = in_init ? gen_r[j*W +: W] : fb;
            assign mb = in_init ? root_r : gen_r[j*W +: W];
            rse_gf_mul #(
                .W(W),
                .FIELD(FIELD)
            ) u_mul (
                .a(ma),
                .b(mb),
                .p(prod[j*W +: W])
            );
            if (j == 0) begin : g_lo
                assign gen_upd[W-1:0] = prod[W-1:0]; // RULE_12
                assign lfsr_upd[W-1:0] = prod[W-1:0]; // RULE_13
                assign lfsr_sh[W-1:0] = {W{1'b0}};
            end else begin : g_hi
                assign gen_upd[j*W +: W] =
                    gen_r[(j-1)*W +: W] ^ prod[j*W +: W]; // RULE_12
                assign lfsr_upd[j*W +: W] =
                    lfsr_r[(j-1)*W +: W] ^ prod[j*W +: W]; // RULE_13
                assign lfsr_sh[j*W +: W] = lfsr_r[(j-1)*W +: W];
            end
        end
    endgenerate

    // ======================================================================
    // next state
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        info_nxt = info_r;
        root_nxt = root_r;
        gen_nxt = gen_r;
        lfsr_nxt = lfsr_r;
        ready_nxt = IN_READY;
        odata_nxt = d1_r;
        ovalid_nxt = 1'b0;
        ocheck_nxt = 1'b0;
        olast_nxt = 1'b0;
        case (state_r)
            `RSE_ST_INIT: begin
                // multiply in one factor (x - alpha^i) per cycle
                if (CFG_OK && cnt_r != R[CNT_W-1:0]) begin
                    gen_nxt = gen_upd; // RULE_12
                    root_nxt = {root_r[W-2:0], 1'b0} ^
                        (root_r[W-1] ? FLD[W-1:0] : {W{1'b0}});
                    cnt_nxt = cnt_r + CNT_ONE;
                end else if (CFG_OK) begin
                    state_nxt = `RSE_ST_DATA;
                    cnt_nxt = {CNT_W{1'b0}};
                    ready_nxt = 1'b1;
                end
            end
            `RSE_ST_DATA: begin
                if (accept) begin
                    info_nxt = last_eff ? {CNT_W{1'b0}} : info_r + CNT_ONE;
                    if (last_eff) begin
                        ready_nxt = 1'b0;
                    end
                end
                // information symbol passes unchanged
                if (v1_r) begin
                    odata_nxt = d1_r; // RULE_02
                    ovalid_nxt = 1'b1; // RULE_08
                    lfsr_nxt = lfsr_upd; // RULE_13
                end
                if (l1_r) begin
                    state_nxt = `RSE_ST_CHK; // RULE_02
                    cnt_nxt = {CNT_W{1'b0}};
                end
            end
            `RSE_ST_CHK: begin
                // remainder leaves highest term first
                odata_nxt = lfsr_r[R*W-1 -: W]; // RULE_02
                ovalid_nxt = 1'b1;
                ocheck_nxt = 1'b1;
                lfsr_nxt = lfsr_sh;
                cnt_nxt = cnt_r + CNT_ONE;
                if (cnt_r == R_LAST) begin
                    olast_nxt = 1'b1; // RULE_05
                    state_nxt = `RSE_ST_DATA;
                    cnt_nxt = {CNT_W{1'b0}};
                    ready_nxt = 1'b1; // RULE_10
                end
            end
            default: begin
                state_nxt = `RSE_ST_INIT;
                ready_nxt = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // registers
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= `RSE_ST_INIT;
            cnt_r <= {CNT_W{1'b0}};
            info_r <= {CNT_W{1'b0}};
            root_r <= ROOT0; // RULE_06
            gen_r <= {{(R-1)*W{1'b0}}, SYM_ONE};
            lfsr_r <= {R*W{1'b0}};
            d1_r <= {W{1'b0}};
            v1_r <= 1'b0;
            l1_r <= 1'b0;
            IN_READY <= 1'b0;
            OUT_DATA <= {W{1'b0}};
            OUT_VALID <= 1'b0;
            OUT_CHECK <= 1'b0;
            OUT_LAST <= 1'b0;
            CFG_ERR <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            info_r <= info_nxt;
            root_r <= root_nxt;
            gen_r <= gen_nxt;
            lfsr_r <= lfsr_nxt;
            // first of the two pipeline stages
            d1_r <= IN_DATA; // RULE_07
            v1_r <= accept; // RULE_10
            l1_r <= accept & last_eff;
            IN_READY <= ready_nxt;
            OUT_DATA <= odata_nxt; // RULE_07
            OUT_VALID <= ovalid_nxt;
            OUT_CHECK <= ocheck_nxt;
            OUT_LAST <= olast_nxt;
            CFG_ERR <= ~CFG_OK;
        end
    end
endmodule

// file: verilog/rse_gf_mul.v
`include "rse_consts.vh"
// ==========================================================================
// galois field multiplier
module rse_gf_mul #(
    parameter W = `RSE_SYM_W_DEF,
    parameter FIELD = `RSE_FIELD_DEF
) (
    input wire [W-1:0] a,
    input wire [W-1:0] b,
    output reg [W-1:0] p
);
    localparam [W:0] FLD = FIELD[W:0];
    reg [W-1:0] aa;
    integer i;

    // shift and add, reduced by the field polynomial
    always @* begin
        p = {W{1'b0}};
        aa = a;
        for (i = 0; i < W; i = i + 1) begin
            if (b[i]) begin
                p = p ^ aa; // RULE_03
            end
            aa = {aa[W-2:0], 1'b0} ^ (aa[W-1] ? FLD[W-1:0] : {W{1'b0}});
        end
    end
endmodule
